/* File: rtl/pm_event_pkg.sv */
package pm_event_pkg;

    // Register offsets inside the power-management I/O block.
    localparam logic [1:0] OFS_STATUS = 2'h0;
    localparam logic [1:0] OFS_ENABLE = 2'h2;

    // Configuration-space offset of the power-management base address.
    localparam logic [7:0] CFG_OFS_PM_BASE = 8'h40;
    localparam int BASE_LSB = 6;
    localparam logic [31:0] CFG_UNMAPPED = 32'h0000_0000;

    // Bit positions shared by the status and enable registers.
    localparam int BIT_WAKE = 15;
    localparam int BIT_OVERRIDE = 11;
    localparam int BIT_ALARM = 10;
    localparam int BIT_BUTTON = 8;
    localparam int BIT_GLOBAL = 5;
    localparam int BIT_BUS_MASTER = 4;
    localparam int BIT_TIMER = 0;

    // Implemented bits; everything else is reserved and reads as zero.
    localparam logic [15:0] STATUS_MASK = 16'h8d31;
    localparam logic [15:0] ENABLE_MASK = 16'h0521;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] PM_BASE_RESET = 16'h0000;

    // Clock rate and the two button times, as printed, then in cycles.
    localparam longint CLK_HZ = 100_000_000;
    localparam longint DEBOUNCE_MS = 16;
    localparam longint OVERRIDE_S = 4;
    localparam longint DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ + 999) / 1000;
    localparam longint OVERRIDE_CYC = OVERRIDE_S * CLK_HZ + 1;
    localparam int CNT_W = 29;

    // Power button sequencer states.
    typedef enum logic [1:0] {
        BTN_IDLE,
        BTN_PRESSED,
        BTN_OVERRIDDEN
    } btn_state_e;

    // One I/O cycle from the host as seen by the register bank.
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [1:0] be;
        logic [15:0] wdata;
    } io_req_s;

    // One configuration cycle towards function 3.
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [31:0] wdata;
    } cfg_req_s;

endpackage

/* File: rtl/button_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module button_timer
    import pm_event_pkg::*;
#(
    parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYC),
    parameter logic [CNT_W-1:0] OVERRIDE_CYCLES = CNT_W'(OVERRIDE_CYC)
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic power_button_n_i,
    output logic press_o,
    output logic override_o
);

    typedef struct packed {
        btn_state_e st;
        logic [CNT_W-1:0] cnt;
        logic press;
        logic override;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;

    // Counts how long the button has been held low; a release restarts everything.
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.press = 1'b0;
        cur_nxt.override = 1'b0;
        if (power_button_n_i) begin
            cur_nxt.st = BTN_IDLE;
            cur_nxt.cnt = '0;
        end else begin
            if (cur_r.st != BTN_OVERRIDDEN) begin
                cur_nxt.cnt = cur_r.cnt + CNT_W'(1);
            end
            case (cur_r.st)
                BTN_IDLE: begin
                    if (cur_nxt.cnt == DEBOUNCE_CYCLES) begin
                        cur_nxt.press = 1'b1;
                        cur_nxt.st = BTN_PRESSED;
                    end
                end
                BTN_PRESSED: begin
                    if (cur_nxt.cnt == OVERRIDE_CYCLES) begin
                        cur_nxt.override = 1'b1;
                        cur_nxt.st = BTN_OVERRIDDEN;
                    end
                end
                BTN_OVERRIDDEN: begin
                    cur_nxt.st = BTN_OVERRIDDEN;
                end
                default: begin
                    cur_nxt.st = BTN_IDLE;
                end
            endcase
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cur_r <= '{st: BTN_IDLE, cnt: '0, press: 1'b0, override: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign press_o = cur_r.press;
    assign override_o = cur_r.override;

endmodule

`default_nettype wire

/* File: rtl/pm_event_status_enable.sv */
`timescale 1ns/1ps
`default_nettype none

module pm_event_status_enable
    import pm_event_pkg::*;
#(
    parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYC),
    parameter logic [CNT_W-1:0] OVERRIDE_CYCLES = CNT_W'(OVERRIDE_CYC)
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_ack_o,
    input wire logic pm_io_space_enable_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [1:0] io_be_i,
    input wire logic [15:0] io_wdata_i,
    output logic [15:0] io_rdata_o,
    output logic io_hit_o,
    input wire logic power_button_n_i,
    input wire logic override_enable_i,
    input wire logic rtc_irq_i,
    input wire logic [3:0] pci_request_in_i,
    input wire logic pci_hold_request_n_i,
    input wire logic pm_timer_bit23_i,
    input wire logic firmware_release_i,
    input wire logic acpi_irq_enable_i,
    input wire logic sleeping_i,
    output logic sci_req_o,
    output logic mgmt_interrupt_n_o,
    output logic system_on_o,
    output logic soft_off_o
);

    // Everything the bank remembers, registered as one word.
    typedef struct packed {
        logic [15:0] pm_base;
        logic [15:0] status;
        logic [15:0] enable;
        logic rtc_prev;
        logic tmr_prev;
        logic tmr_seen;
        logic [15:0] io_rdata;
        logic io_hit;
        logic [31:0] cfg_rdata;
        logic cfg_ack;
        logic sci_req;
        logic smi_n;
        logic system_on;
        logic soft_off;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;

    io_req_s io_req;
    cfg_req_s cfg_req;

    logic btn_press;
    logic btn_override;

    // Expands the two byte enables into a 16-bit lane mask.
    function automatic logic [15:0] lane_mask(input logic [1:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // Checks whether a host I/O address falls on a given register offset.
    function automatic logic io_decode(input logic [15:0] addr, input logic [15:0] base,
                                       input logic [1:0] ofs);
        io_decode = (addr[15:BASE_LSB] == base[15:BASE_LSB])
                    && (addr[BASE_LSB-1:2] == '0) && (addr[1:0] == {ofs[1], 1'b0});
    endfunction

    // Gathers the bus pins into the request carriers.
    assign io_req = '{addr: io_addr_i, rd: io_rd_i, wr: io_wr_i, be: io_be_i, wdata: io_wdata_i};
    assign cfg_req = '{addr: cfg_addr_i, rd: cfg_rd_i, wr: cfg_wr_i, wdata: cfg_wdata_i};

    // Debounce and override timing of the power button.
    button_timer #(
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
        .OVERRIDE_CYCLES(OVERRIDE_CYCLES)
    ) u_button_timer (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .power_button_n_i(power_button_n_i),
        .press_o(btn_press),
        .override_o(btn_override)
    );

    // Next-state logic of the whole bank.
    always_comb begin
        logic hit_sts;
        logic hit_en;
        logic [15:0] lanes;
        logic [15:0] set_bits;
        logic [15:0] clr_bits;
        logic [15:0] hw_clr;
        logic override_evt;
        logic alarm_evt;
        logic timer_evt;
        logic resume_evt;
        logic btn_req;
        hit_sts = 1'b0;
        hit_en = 1'b0;
        lanes = 16'h0000;
        set_bits = 16'h0000;
        clr_bits = 16'h0000;
        hw_clr = 16'h0000;
        override_evt = 1'b0;
        alarm_evt = 1'b0;
        timer_evt = 1'b0;
        resume_evt = 1'b0;
        btn_req = 1'b0;
        cur_nxt = cur_r;

        // Configuration port: only the base address dword is mapped.
        cur_nxt.cfg_ack = cfg_req.rd | cfg_req.wr;
        cur_nxt.cfg_rdata = CFG_UNMAPPED;
        if (cfg_req.addr[7:2] == CFG_OFS_PM_BASE[7:2]) begin
            if (cfg_req.wr) begin
                cur_nxt.pm_base = {cfg_req.wdata[15:BASE_LSB], {BASE_LSB{1'b0}}};
            end
            if (cfg_req.rd) begin
                cur_nxt.cfg_rdata = {16'h0000, cur_r.pm_base[15:1], 1'b1};
            end
        end

        // I/O decode is live only while the space enable is set.
        if (pm_io_space_enable_i) begin
            hit_sts = io_decode(io_req.addr, cur_r.pm_base, OFS_STATUS);
            hit_en = io_decode(io_req.addr, cur_r.pm_base, OFS_ENABLE);
        end
        lanes = lane_mask(io_req.be);
        cur_nxt.io_hit = (hit_sts | hit_en) & (io_req.rd | io_req.wr);
        cur_nxt.io_rdata = 16'h0000;
        if (io_req.rd && hit_sts) begin
            cur_nxt.io_rdata = cur_r.status & STATUS_MASK & lanes;
        end
        if (io_req.rd && hit_en) begin
            cur_nxt.io_rdata = cur_r.enable & ENABLE_MASK & lanes;
        end

        // Enable register: plain read/write of the implemented bits.
        if (io_req.wr && hit_en) begin
            cur_nxt.enable = (cur_r.enable & ~lanes)
                             | (io_req.wdata & lanes & ENABLE_MASK);
        end

        // Software clear: ones clear, zeros leave the flag alone.
        if (io_req.wr && hit_sts) begin
            clr_bits = io_req.wdata & lanes & STATUS_MASK;
        end

        // Hardware event detection.
        override_evt = btn_press ? 1'b0 : (btn_override & override_enable_i);
        alarm_evt = rtc_irq_i & ~cur_r.rtc_prev;
        cur_nxt.rtc_prev = rtc_irq_i;
        cur_nxt.tmr_prev = pm_timer_bit23_i;
        cur_nxt.tmr_seen = 1'b1;
        timer_evt = cur_r.tmr_seen & (pm_timer_bit23_i ^ cur_r.tmr_prev);

        // Resume: button always, alarm only when enabled.
        resume_evt = sleeping_i
                     & (btn_press | (alarm_evt & cur_r.enable[BIT_ALARM]));

        // Hardware set terms, one per flag.
        set_bits[BIT_WAKE] = resume_evt;
        set_bits[BIT_OVERRIDE] = override_evt;
        set_bits[BIT_ALARM] = alarm_evt;
        set_bits[BIT_BUTTON] = btn_press;
        set_bits[BIT_GLOBAL] = firmware_release_i & cur_r.enable[BIT_GLOBAL];
        set_bits[BIT_BUS_MASTER] = (|pci_request_in_i) | ~pci_hold_request_n_i;
        set_bits[BIT_TIMER] = timer_evt;

        // Override takes the button flag away.
        hw_clr[BIT_BUTTON] = override_evt;

        // Set wins over any clear; software alone can never set.
        cur_nxt.status = ((cur_r.status & ~clr_bits & ~hw_clr) | set_bits) & STATUS_MASK;

        // Power state requests are one-cycle pulses.
        cur_nxt.system_on = resume_evt;
        cur_nxt.soft_off = override_evt;

        // Request lines follow the flags and enables.
        btn_req = cur_r.status[BIT_BUTTON] & cur_r.enable[BIT_BUTTON];
        cur_nxt.sci_req = (cur_r.status[BIT_TIMER] & cur_r.enable[BIT_TIMER])
                          | (cur_r.status[BIT_GLOBAL] & cur_r.enable[BIT_GLOBAL])
                          | (btn_req & acpi_irq_enable_i);
        cur_nxt.smi_n = ~(btn_req & ~acpi_irq_enable_i);
    end

    // State register with synchronous reset to the documented defaults.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cur_r <= '{
                pm_base: PM_BASE_RESET,
                status: STATUS_RESET,
                enable: ENABLE_RESET,
                rtc_prev: 1'b0,
                tmr_prev: 1'b0,
                tmr_seen: 1'b0,
                io_rdata: 16'h0000,
                io_hit: 1'b0,
                cfg_rdata: 32'h0000_0000,
                cfg_ack: 1'b0,
                sci_req: 1'b0,
                smi_n: 1'b1,
                system_on: 1'b0,
                soft_off: 1'b0
            };
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Every output is a field of the state register.
    assign cfg_rdata_o = cur_r.cfg_rdata;
    assign cfg_ack_o = cur_r.cfg_ack;
    assign io_rdata_o = cur_r.io_rdata;
    assign io_hit_o = cur_r.io_hit;
    assign sci_req_o = cur_r.sci_req;
    assign mgmt_interrupt_n_o = cur_r.smi_n;
    assign system_on_o = cur_r.system_on;
    assign soft_off_o = cur_r.soft_off;

endmodule

`default_nettype wire

/* File: verif/pm_event_status_enable_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module pm_event_status_enable_asserts
    import pm_event_pkg::*;
#(
    parameter logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_CYC),
    parameter logic [CNT_W-1:0] OVERRIDE_CYCLES = CNT_W'(OVERRIDE_CYC)
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_ack_o,
    input wire logic pm_io_space_enable_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [15:0] io_rdata_o,
    input wire logic io_hit_o,
    input wire logic power_button_n_i,
    input wire logic sleeping_i,
    input wire logic sci_req_o,
    input wire logic mgmt_interrupt_n_o,
    input wire logic system_on_o,
    input wire logic soft_off_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // Length of the current unbroken button press, saturating.
    logic [CNT_W-1:0] low_run_r;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || power_button_n_i)
            low_run_r <= '0;
        else if (low_run_r != '1)
            low_run_r <= low_run_r + 1'b1;
    end

    // A configuration strobe and an I/O strobe as taken by the block.
    sequence cfg_strobe_seq;
        cfg_rd_i || cfg_wr_i;
    endsequence
    sequence io_taken_seq;
        $past(pm_io_space_enable_i) && $past(io_rd_i || io_wr_i);
    endsequence

    a_cfg_ack_timing: assert property (cfg_strobe_seq |=> cfg_ack_o)
        else $error("config strobe not acknowledged next cycle");
    a_cfg_ack_only: assert property (!(cfg_rd_i || cfg_wr_i) |=> !cfg_ack_o)
        else $error("config ack without strobe");
    a_cfg_other_zero: assert property (cfg_ack_o && $past(cfg_addr_i[7:2]) != 6'h10 |-> cfg_rdata_o == '0)
        else $error("unmapped config read not zero");
    a_cfg_io_flag: assert property (cfg_ack_o && $past(cfg_rd_i) && $past(cfg_addr_i[7:2]) == 6'h10 |-> cfg_rdata_o[0])
        else $error("base read lacks io indicator");
    a_hit_needs_enable: assert property (io_hit_o |-> io_taken_seq and ($past(io_addr_i[5:2]) == 4'h0 && !$past(io_addr_i[0])))
        else $error("io hit without decoded request");
    a_idle_rdata_zero: assert property (!io_hit_o |-> io_rdata_o == '0)
        else $error("read data outside a hit");
    a_reserved_zero: assert property ((io_rdata_o & ~STATUS_MASK) == 16'h0000)
        else $error("reserved bits read nonzero");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> !sci_req_o && mgmt_interrupt_n_o && !system_on_o && !soft_off_o)
        else $error("outputs not idle after reset");
    a_wake_while_sleep: assert property (!sleeping_i [*3] |-> !system_on_o)
        else $error("resume while awake");
    a_off_after_hold: assert property (soft_off_o |-> $past(low_run_r, 2) >= OVERRIDE_CYCLES - 3)
        else $error("soft off without long press");
    a_on_pulse: assert property (system_on_o |=> !system_on_o)
        else $error("system on longer than one cycle");
    a_off_pulse: assert property (soft_off_o |=> !soft_off_o)
        else $error("soft off longer than one cycle");
endmodule

bind pm_event_status_enable pm_event_status_enable_asserts #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .OVERRIDE_CYCLES(OVERRIDE_CYCLES)
) pm_event_status_enable_asserts_i (.mclk_i, .rst_n_i, .cfg_addr_i, .cfg_rd_i, .cfg_wr_i, .cfg_rdata_o,
    .cfg_ack_o, .pm_io_space_enable_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_rdata_o, .io_hit_o,
    .power_button_n_i, .sleeping_i, .sci_req_o, .mgmt_interrupt_n_o, .system_on_o, .soft_off_o);

`default_nettype wire

/* File: verif/pm_event_status_enable_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module pm_event_status_enable_tb
    import pm_event_pkg::*;
();
    localparam logic [15:0] ST = 16'h0440;
    localparam logic [15:0] EN = 16'h0442;
    localparam int DEB = 8;
    localparam int OVR = 40;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, cfg_rd_i = 1'b0, cfg_wr_i = 1'b0, pm_io_space_enable_i = 1'b0;
    logic io_rd_i = 1'b0, io_wr_i = 1'b0, power_button_n_i = 1'b1, override_enable_i = 1'b0, rtc_irq_i = 1'b0;
    logic pci_hold_request_n_i = 1'b1, pm_timer_bit23_i = 1'b0, firmware_release_i = 1'b0;
    logic acpi_irq_enable_i = 1'b0, sleeping_i = 1'b0, cfg_ack_o, io_hit_o, sci_req_o, mgmt_interrupt_n_o;
    logic system_on_o, soft_off_o;
    logic [7:0] cfg_addr_i = 8'h40;
    logic [31:0] cfg_wdata_i = 32'h0000_0000, cfg_rdata_o, d, r, seed = 32'h0001_7c4e;
    logic [15:0] io_addr_i = 16'h0000, io_wdata_i = 16'h0000, io_rdata_o, exp, en;
    logic [1:0] io_be_i = 2'b11;
    logic [3:0] pci_request_in_i = 4'h0;
    int error_cnt = 0, cmp_count = 0, cycles = 0, n;

    pm_event_status_enable #(.DEBOUNCE_CYCLES(CNT_W'(DEB)), .OVERRIDE_CYCLES(CNT_W'(OVR))) pm_event_status_enable_i (
        .mclk_i, .rst_n_i, .cfg_addr_i, .cfg_rd_i, .cfg_wr_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_ack_o,
        .pm_io_space_enable_i, .io_addr_i, .io_rd_i, .io_wr_i, .io_be_i, .io_wdata_i, .io_rdata_o, .io_hit_o,
        .power_button_n_i, .override_enable_i, .rtc_irq_i, .pci_request_in_i, .pci_hold_request_n_i,
        .pm_timer_bit23_i, .firmware_release_i, .acpi_irq_enable_i, .sleeping_i, .sci_req_o,
        .mgmt_interrupt_n_o, .system_on_o, .soft_off_o);

    // Free running clock and a cycle ceiling that cuts a hang short.
    always #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Flags that one random burst of pin events must leave set.
    function automatic logic [15:0] event_flags(input logic [31:0] v);
        event_flags = 16'h0000;
        event_flags[BIT_ALARM] = v[5];
        event_flags[BIT_BUS_MASTER] = (|v[3:0]) | !v[4];
        event_flags[BIT_TIMER] = v[6];
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge mclk_i);
    endtask

    // Config and I/O cycles: strobe for one edge, look at the answer except on I/O writes, then let one idle edge pass.
    task automatic cfg_op(input logic wr, input logic [31:0] w);
        cfg_wr_i = wr;
        cfg_rd_i = !wr;
        cfg_wdata_i = w;
        tick(1);
        cfg_wr_i = 1'b0;
        cfg_rd_i = 1'b0;
        check("cfg ack", cfg_ack_o, 1'b1);
        d = cfg_rdata_o;
        tick(1);
    endtask

    task automatic io_wr(input logic [15:0] a, input logic [15:0] w);
        io_addr_i = a;
        io_wdata_i = w;
        io_wr_i = 1'b1;
        tick(1);
        io_wr_i = 1'b0;
        tick(1);
    endtask

    task automatic io_rd(input logic [15:0] a, input logic [15:0] e, input logic h);
        io_addr_i = a;
        io_rd_i = 1'b1;
        tick(1);
        io_rd_i = 1'b0;
        check("io hit", io_hit_o, h);
        check("io data", io_rdata_o, e);
        tick(1);
    endtask

    // Waits a bounded time for a one-cycle pulse on system on or soft off.
    task automatic wait_pulse(input logic off, input int lim);
        n = 0;
        while (!(off ? soft_off_o : system_on_o) && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    initial begin
        tick(20);
        rst_n_i = 1'b1;
        cfg_op(1'b0, 32'h0000_0000);
        check("base reset", d, 32'h0000_0001);
        cfg_op(1'b1, 32'h0000_0440);
        cfg_op(1'b0, 32'h0000_0000);
        check("base", d, 32'h0000_0441);
        // Any other configuration offset is acknowledged, reads zero and keeps the base.
        cfg_addr_i = 8'h44;
        cfg_op(1'b1, 32'hffff_ffff);
        cfg_op(1'b0, 32'h0000_0000);
        check("cfg other", d, CFG_UNMAPPED);
        cfg_addr_i = 8'h40;
        cfg_op(1'b0, 32'h0000_0000);
        check("base kept", d, 32'h0000_0441);
        io_rd(ST, 16'h0000, 1'b0);
        pm_io_space_enable_i = 1'b1;
        io_rd(ST, STATUS_RESET, 1'b1);
        io_rd(EN, ENABLE_RESET, 1'b1);
        io_rd(ST + 16'h0001, 16'h0000, 1'b0);
        io_rd(ST + 16'h0004, 16'h0000, 1'b0);
        io_wr(EN, 16'hffff);
        io_rd(EN, ENABLE_MASK, 1'b1);
        io_be_i = 2'b01;
        io_wr(EN, 16'h0000);
        io_be_i = 2'b11;
        io_rd(EN, 16'h0500, 1'b1);
        io_wr(EN, 16'h0000);
        io_wr(ST, 16'hffff);
        io_rd(ST, 16'h0000, 1'b1);
        // Random bursts of hardware events, then zero writes and exact clears.
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            pci_request_in_i = r[3:0];
            pci_hold_request_n_i = r[4];
            rtc_irq_i = r[5];
            pm_timer_bit23_i = pm_timer_bit23_i ^ r[6];
            exp = event_flags(r);
            tick(1);
            pci_request_in_i = 4'h0;
            pci_hold_request_n_i = 1'b1;
            rtc_irq_i = 1'b0;
            tick(1);
            io_rd(ST, exp, 1'b1);
            io_wr(ST, 16'h0000);
            io_rd(ST, exp, 1'b1);
            io_wr(ST, exp);
            io_rd(ST, 16'h0000, 1'b1);
        end
        // A bus request on the very edge of a clearing write must survive it.
        io_addr_i = ST;
        io_wdata_i = 16'hffff;
        io_wr_i = 1'b1;
        pci_request_in_i = 4'h2;
        tick(1);
        io_wr_i = 1'b0;
        pci_request_in_i = 4'h0;
        tick(1);
        io_rd(ST, 16'h0010, 1'b1);
        io_wr(ST, 16'hffff);
        // Timer and global sources with their enables off and on.
        acpi_irq_enable_i = 1'b1;
        for (int k = 0; k < 4; k++) begin
            en = k[0] ? (k[1] ? 16'h0020 : 16'h0001) : 16'h0000;
            io_wr(EN, en);
            firmware_release_i = k[1];
            pm_timer_bit23_i = pm_timer_bit23_i ^ !k[1];
            tick(1);
            firmware_release_i = 1'b0;
            tick(2);
            check("sci", sci_req_o, k[0]);
            io_rd(ST, k[1] ? (k[0] ? 16'h0020 : 16'h0000) : 16'h0001, 1'b1);
            io_wr(ST, 16'hffff);
            tick(2);
            check("sci clear", sci_req_o, 1'b0);
        end
        // Long press while asleep: resume, request, then override to soft off.
        io_wr(EN, 16'h0100);
        sleeping_i = 1'b1;
        override_enable_i = 1'b1;
        power_button_n_i = 1'b0;
        wait_pulse(1'b0, 20);
        check("debounce", n, DEB + 1);
        tick(2);
        check("sci button", sci_req_o, 1'b1);
        check("smi idle", mgmt_interrupt_n_o, 1'b1);
        // With the SCI enable off the button request goes out as an SMI instead.
        acpi_irq_enable_i = 1'b0;
        tick(2);
        check("smi button", mgmt_interrupt_n_o, 1'b0);
        check("sci gated", sci_req_o, 1'b0);
        acpi_irq_enable_i = 1'b1;
        io_rd(ST, 16'h8100, 1'b1);
        wait_pulse(1'b1, 50);
        check("soft off", soft_off_o, 1'b1);
        tick(2);
        io_rd(ST, 16'h8800, 1'b1);
        power_button_n_i = 1'b1;
        io_wr(ST, 16'hffff);
        io_wr(EN, 16'h0400);
        rtc_irq_i = 1'b1;
        wait_pulse(1'b0, 6);
        check("alarm wake", system_on_o, 1'b1);
        rtc_irq_i = 1'b0;
        tick(1);
        io_rd(ST, 16'h8400, 1'b1);
        sleeping_i = 1'b0;
        // Long press with override disabled: the button flag stays and no soft off follows.
        io_wr(ST, 16'hffff);
        override_enable_i = 1'b0;
        power_button_n_i = 1'b0;
        tick(OVR + 4);
        check("no override", soft_off_o, 1'b0);
        io_rd(ST, 16'h0100, 1'b1);
        power_button_n_i = 1'b1;
        close_out();
    end
endmodule

`default_nettype wire
